// ---- core/ofc_config_regs.sv ----
// configuration register bank of the octal serial flash, core side plus link-facing front
// assumes link commands arrive on linkClock with cmdValid/cmdReady and held data
`timescale 1ns/1ps

module ofc_config_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic linkClock,
  input wire logic cmdValid,
  input wire ofc_pkg::ofc_cmd_type cmdWord,
  output logic cmdReady,
  output logic rspValid,
  output logic [7:0] rspData,
  input wire logic dummyActive,
  output logic preambleDrive,
  output logic [7:0] preambleLines,
  input wire logic eccEvent,
  input wire logic [2:0] eccKind,
  output ofc_pkg::ofc_cfg_type config_out,
  output logic [4:0] dummyCycleCount,
  output logic [7:0] crcChunkBytes,
  output logic errorSignalN
);

  // ******************************************
  // address decoding shared by reads and writes, and the error pin condition
  // ******************************************
  function automatic ofc_pkg::ofc_reg_type decodeAddr(input logic [31:0] a);
    unique case (a)
      ofc_pkg::ADDR_MODE: decodeAddr = ofc_pkg::REG_MODE;
      ofc_pkg::ADDR_STROBE: decodeAddr = ofc_pkg::REG_STROBE;
      ofc_pkg::ADDR_DUMMY: decodeAddr = ofc_pkg::REG_DUMMY;
      ofc_pkg::ADDR_ERRPIN: decodeAddr = ofc_pkg::REG_ERRPIN;
      ofc_pkg::ADDR_CRC: decodeAddr = ofc_pkg::REG_CRC;
      ofc_pkg::ADDR_ECC: decodeAddr = ofc_pkg::REG_ECC;
      default: decodeAddr = ofc_pkg::REG_NONE;
    endcase
  endfunction : decodeAddr

  function automatic logic errorCondition(input logic [1:0] c, input logic [2:0] k);
    unique case (c)
      2'h0: errorCondition = k[1] | k[2];
      2'h1: errorCondition = |k;
      2'h2: errorCondition = k[1];
      2'h3: errorCondition = k[0] | k[1];
    endcase
  endfunction : errorCondition

  // ******************************************
  // reset release, one pair per domain
  // ******************************************
  logic coreRst1;
  logic coreRst2;
  logic linkRst1;
  logic linkRst2;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      coreRst1 <= 1'b0;
      coreRst2 <= 1'b0;
    end else begin
      coreRst1 <= 1'b1;
      coreRst2 <= coreRst1;
    end
  end

  always_ff @(posedge linkClock or negedge resetn) begin
    if (!resetn) begin
      linkRst1 <= 1'b0;
      linkRst2 <= 1'b0;
    end else begin
      linkRst1 <= 1'b1;
      linkRst2 <= linkRst1;
    end
  end

  // ******************************************
  // core domain state
  // ******************************************
  typedef struct packed {
    logic reqSync1;
    logic reqSync2;
    logic reqSeen;
    logic ackToggle;
    logic [7:0] readData;
    ofc_pkg::ofc_cfg_type cfg;
    logic failAddressValid;
    logic [2:0] eccFailKind;
    logic [3:0] failChunkCounter;
    logic errorN;
    logic [4:0] dummyCount;
    logic [7:0] chunkBytes;
  } ofc_core_type;

  // ******************************************
  // link domain state
  // ******************************************
  typedef struct packed {
    logic reqToggle;
    logic idle;
    ofc_pkg::ofc_cmd_type cmd;
    logic ackSync1;
    logic ackSync2;
    logic ackSeen;
    logic rspValid;
    logic [7:0] rspData;
    logic enSync1;
    logic enSync2;
    logic selSync1;
    logic selSync2;
    logic [3:0] bitIndex;
    logic drive;
    logic [7:0] lines;
  } ofc_link_type;

  localparam ofc_core_type CORE_RESET = '{
    cfg: '{driveStrengthCode: ofc_pkg::DRIVE_RESET, modeCode: ofc_pkg::MODE_SINGLE,
           default: '0},
    dummyCount: ofc_pkg::DUMMY_MAX,
    chunkBytes: ofc_pkg::CRC_CHUNK_MIN,
    errorN: 1'b1,
    default: '0};

  // link side leaves reset ready, so cmdReady is a plain flop output
  localparam ofc_link_type LINK_RESET = '{idle: 1'b1, default: '0};

  ofc_core_type core;
  ofc_core_type next_core;
  ofc_link_type link;
  ofc_link_type next_link;

  // ******************************************
  // core: register execution and ECC status
  // ******************************************
  always_comb begin
    ofc_pkg::ofc_cmd_type c;
    ofc_pkg::ofc_reg_type r;
    logic eccClear;
    c = link.cmd;
    r = decodeAddr(c.address);
    eccClear = 1'b0;
    next_core = core;
    next_core.reqSync1 = link.reqToggle;
    next_core.reqSync2 = core.reqSync1;
    // command word is held by the link side until the ack returns, so it is stable here
    if (core.reqSync2 != core.reqSeen) begin
      next_core.reqSeen = core.reqSync2;
      next_core.ackToggle = ~core.ackToggle;
      next_core.readData = 8'h00;
      unique case (c.opcode)
        ofc_pkg::OP_WRITE_STATUS: begin
          next_core.cfg.driveStrengthCode = c.data[ofc_pkg::DRIVE_LSB +: 3];
          // one-time bit: can be set but never cleared by a write
          next_core.cfg.protectOriginSelect = core.cfg.protectOriginSelect
                                              | c.data[ofc_pkg::ORIGIN_BIT];
          next_core.cfg.preambleEnable = c.data[ofc_pkg::PREAMBLE_EN_BIT];
        end
        ofc_pkg::OP_READ_CONFIG: begin
          next_core.readData[ofc_pkg::DRIVE_LSB +: 3] = core.cfg.driveStrengthCode;
          next_core.readData[ofc_pkg::ORIGIN_BIT] = core.cfg.protectOriginSelect;
          next_core.readData[ofc_pkg::PREAMBLE_EN_BIT] = core.cfg.preambleEnable;
        end
        ofc_pkg::OP_WRITE_CONFIG2: begin
          unique case (r)
            ofc_pkg::REG_MODE: begin
              // refuse inhibited code and a direct jump between octal modes
              if (c.data[1:0] != ofc_pkg::MODE_INHIBIT &&
                  (core.cfg.modeCode == ofc_pkg::MODE_SINGLE ||
                   c.data[1:0] == ofc_pkg::MODE_SINGLE)) begin
                next_core.cfg.modeCode = c.data[1:0];
              end
            end
            ofc_pkg::REG_STROBE: begin
              next_core.cfg.strobeInSingleRate = c.data[ofc_pkg::STROBE_SR_BIT];
              next_core.cfg.strobePreCycle = c.data[ofc_pkg::STROBE_PRE_BIT];
            end
            ofc_pkg::REG_DUMMY: next_core.cfg.dummyCycleCode = c.data[2:0];
            ofc_pkg::REG_ERRPIN: next_core.cfg.errorPinConditionCode = c.data[1:0];
            ofc_pkg::REG_CRC: begin
              next_core.cfg.crcChunkSize = c.data[ofc_pkg::CRC_SIZE_LSB +: 2];
              next_core.cfg.crcOutputEnable = c.data[ofc_pkg::CRC_OUT_BIT];
              next_core.cfg.preamblePatternSelect = c.data[ofc_pkg::PATTERN_SEL_BIT];
            end
            ofc_pkg::REG_ECC: eccClear = (c.data == ofc_pkg::ECC_CLEAR_DATA);
            default: ;
          endcase
        end
        ofc_pkg::OP_READ_CONFIG2: begin
          unique case (r)
            ofc_pkg::REG_MODE: next_core.readData[1:0] = core.cfg.modeCode;
            ofc_pkg::REG_STROBE: begin
              next_core.readData[ofc_pkg::STROBE_SR_BIT] = core.cfg.strobeInSingleRate;
              next_core.readData[ofc_pkg::STROBE_PRE_BIT] = core.cfg.strobePreCycle;
            end
            ofc_pkg::REG_DUMMY: next_core.readData[2:0] = core.cfg.dummyCycleCode;
            ofc_pkg::REG_ERRPIN: next_core.readData[1:0] = core.cfg.errorPinConditionCode;
            ofc_pkg::REG_CRC: begin
              next_core.readData[ofc_pkg::CRC_SIZE_LSB +: 2] = core.cfg.crcChunkSize;
              next_core.readData[ofc_pkg::CRC_OUT_BIT] = core.cfg.crcOutputEnable;
              next_core.readData[ofc_pkg::PATTERN_SEL_BIT] = core.cfg.preamblePatternSelect;
            end
            ofc_pkg::REG_ECC: begin
              next_core.readData[ofc_pkg::FAIL_VALID_BIT] = core.failAddressValid;
              next_core.readData[ofc_pkg::FAIL_KIND_LSB +: 3] = core.eccFailKind;
              next_core.readData[ofc_pkg::FAIL_COUNT_LSB +: 4] = core.failChunkCounter;
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // clear first, then the event, so an event in the clearing cycle survives
    if (eccClear) begin
      next_core.failAddressValid = 1'b0;
      next_core.eccFailKind = 3'h0;
      next_core.failChunkCounter = 4'h0;
    end
    if (eccEvent && (|eccKind)) begin
      next_core.failAddressValid = 1'b1;
      next_core.eccFailKind = next_core.eccFailKind | eccKind;
      if (next_core.failChunkCounter != ofc_pkg::FAIL_COUNT_MAX) begin
        next_core.failChunkCounter = next_core.failChunkCounter + 4'h1;
      end
    end
    // derived outputs follow the fields at once
    next_core.errorN = ~errorCondition(next_core.cfg.errorPinConditionCode,
                                       next_core.eccFailKind);
    next_core.dummyCount = ofc_pkg::DUMMY_MAX
                           - {1'b0, next_core.cfg.dummyCycleCode, 1'b0};
    next_core.chunkBytes = ofc_pkg::CRC_CHUNK_MIN
                           << next_core.cfg.crcChunkSize;
  end

  always_ff @(posedge clock or negedge coreRst2) begin
    if (!coreRst2) begin
      core <= CORE_RESET;
    end else begin
      core <= next_core;
    end
  end

  // ******************************************
  // link: command handshake and preamble lines
  // ******************************************
  always_comb begin
    logic [15:0] patLines;
    logic [15:0] patLine3;
    patLines = link.selSync2 ? ofc_pkg::PATTERN_B_LINES : ofc_pkg::PATTERN_A_LINES;
    patLine3 = link.selSync2 ? ofc_pkg::PATTERN_B_LINES : ofc_pkg::PATTERN_A_LINE3;
    next_link = link;
    next_link.rspValid = 1'b0;
    next_link.ackSync1 = core.ackToggle;
    next_link.ackSync2 = link.ackSync1;
    next_link.enSync1 = core.cfg.preambleEnable;
    next_link.enSync2 = link.enSync1;
    next_link.selSync1 = core.cfg.preamblePatternSelect;
    next_link.selSync2 = link.selSync1;
    if (link.idle && cmdValid) begin
      next_link.cmd = cmdWord;
      next_link.reqToggle = ~link.reqToggle;
      next_link.idle = 1'b0;
    end
    if (!link.idle && link.ackSync2 != link.ackSeen) begin
      next_link.ackSeen = link.ackSync2;
      next_link.idle = 1'b1;
      next_link.rspValid = 1'b1;
      next_link.rspData = core.readData;
    end
    // pattern shifts out msb first, restarting with every dummy phase
    next_link.drive = dummyActive & link.enSync2;
    next_link.bitIndex = 4'h0;
    next_link.lines = 8'h00;
    if (dummyActive && link.enSync2) begin
      next_link.bitIndex = link.bitIndex + 4'h1;
      for (int i = 0; i < 8; i++) begin
        next_link.lines[i] = (i == ofc_pkg::DATA_LINE_3) ? patLine3[4'hf - link.bitIndex]
                                                         : patLines[4'hf - link.bitIndex];
      end
    end
  end

  always_ff @(posedge linkClock or negedge linkRst2) begin
    if (!linkRst2) begin
      link <= LINK_RESET;
    end else begin
      link <= next_link;
    end
  end

  assign cmdReady = link.idle;
  assign rspValid = link.rspValid;
  assign rspData = link.rspData;
  assign preambleDrive = link.drive;
  assign preambleLines = link.lines;
  assign config_out = core.cfg;
  assign dummyCycleCount = core.dummyCount;
  assign crcChunkBytes = core.chunkBytes;
  assign errorSignalN = core.errorN;

endmodule : ofc_config_regs

// ---- shared/ofc_pkg.sv ----
// package of the flash configuration register block: map, fields, defaults, types
// assumes a link front end that has already split instructions into opcode, address, data
package ofc_pkg;

  // ******************************************
  // second configuration register set offsets
  // ******************************************
  localparam logic [31:0] ADDR_MODE = 32'h0000_0000;
  localparam logic [31:0] ADDR_STROBE = 32'h0000_0200;
  localparam logic [31:0] ADDR_DUMMY = 32'h0000_0300;
  localparam logic [31:0] ADDR_ERRPIN = 32'h0000_0400;
  localparam logic [31:0] ADDR_CRC = 32'h0000_0500;
  localparam logic [31:0] ADDR_ECC = 32'h0000_0800;

  // ******************************************
  // field positions
  // ******************************************
  localparam int DRIVE_LSB = 0;
  localparam int ORIGIN_BIT = 3;
  localparam int PREAMBLE_EN_BIT = 4;
  localparam int STROBE_SR_BIT = 1;
  localparam int STROBE_PRE_BIT = 0;
  localparam int CRC_SIZE_LSB = 5;
  localparam int CRC_OUT_BIT = 4;
  localparam int PATTERN_SEL_BIT = 0;
  localparam int FAIL_VALID_BIT = 7;
  localparam int FAIL_KIND_LSB = 4;
  localparam int FAIL_COUNT_LSB = 0;

  // ******************************************
  // reset values and codes
  // ******************************************
  localparam logic [2:0] DRIVE_RESET = 3'h7;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_OCTAL_STR = 2'h1;
  localparam logic [1:0] MODE_OCTAL_DTR = 2'h2;
  localparam logic [1:0] MODE_INHIBIT = 2'h3;
  localparam logic [4:0] DUMMY_MAX = 5'h14;
  localparam logic [3:0] FAIL_COUNT_MAX = 4'hf;
  localparam logic [7:0] CRC_CHUNK_MIN = 8'h10;
  localparam logic [7:0] ECC_CLEAR_DATA = 8'h00;
  localparam int DATA_LINE_3 = 3;
  localparam logic [15:0] PATTERN_A_LINES = 16'h349a;
  localparam logic [15:0] PATTERN_A_LINE3 = 16'h3514;
  localparam logic [15:0] PATTERN_B_LINES = 16'h5555;

  typedef enum logic [2:0] {
    OP_WRITE_STATUS, OP_READ_CONFIG, OP_WRITE_CONFIG2, OP_READ_CONFIG2
  } ofc_op_type;

  typedef enum logic [2:0] {
    REG_MODE, REG_STROBE, REG_DUMMY, REG_ERRPIN, REG_CRC, REG_ECC, REG_NONE
  } ofc_reg_type;

  typedef struct packed {
    ofc_op_type opcode;
    logic [31:0] address;
    logic [7:0] data;
  } ofc_cmd_type;

  typedef struct packed {
    logic [2:0] driveStrengthCode;
    logic protectOriginSelect;
    logic preambleEnable;
    logic [1:0] modeCode;
    logic strobeInSingleRate;
    logic strobePreCycle;
    logic [2:0] dummyCycleCode;
    logic [1:0] errorPinConditionCode;
    logic [1:0] crcChunkSize;
    logic crcOutputEnable;
    logic preamblePatternSelect;
  } ofc_cfg_type;

endpackage : ofc_pkg

// ---- tb/ofc_config_regs_monitor.sv ----
// checker of the flash configuration register bank, watching its ports only
// assumes resetn resets both the core and the link domain
`timescale 1ns/1ps
module ofc_config_regs_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic linkClock,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic dummyActive,
  input wire logic preambleDrive,
  input wire logic eccEvent,
  input wire logic [2:0] eccKind,
  input wire ofc_pkg::ofc_cfg_type config_out,
  input wire logic [4:0] dummyCycleCount,
  input wire logic [7:0] crcChunkBytes,
  input wire logic errorSignalN
);
  // ****************************
  // core domain, then link domain, then covers of both domains
  // ****************************
  a_dummy_count: assert property (@(posedge clock) disable iff (!resetn)
    $stable(config_out.dummyCycleCode) |->
    dummyCycleCount == 5'h14 - {1'b0, config_out.dummyCycleCode, 1'b0}) else $error("dummy count");
  a_crc_size: assert property (@(posedge clock) disable iff (!resetn)
    $stable(config_out.crcChunkSize) |-> crcChunkBytes == 8'h10 << config_out.crcChunkSize)
    else $error("chunk size");
  a_two_bit_pin: assert property (@(posedge clock) disable iff (!resetn)
    eccEvent && eccKind[1] |=> !errorSignalN) else $error("error pin stays high");
  a_one_bit_pin: assert property (@(posedge clock) disable iff (!resetn)
    eccEvent && eccKind == 3'h1 && !config_out.errorPinConditionCode[0] && errorSignalN
    |=> errorSignalN) else $error("error pin low on one-bit fix");
  a_mode_path: assert property (@(posedge clock) disable iff (!resetn)
    $changed(config_out.modeCode) |-> config_out.modeCode != 2'h3 &&
    (config_out.modeCode == 2'h0 || $past(config_out.modeCode) == 2'h0)) else $error("mode step");
  a_origin_hold: assert property (@(posedge clock) disable iff (!resetn)
    config_out.protectOriginSelect |=> config_out.protectOriginSelect) else $error("origin lost");
  a_preamble_cause: assert property (@(posedge linkClock) disable iff (!resetn)
    preambleDrive |-> $past(dummyActive)) else $error("preamble outside dummy");
  a_cmd_answer: assert property (@(posedge linkClock) disable iff (!resetn)
    cmdValid && cmdReady |=> !cmdReady ##[1:7] rspValid && cmdReady) else $error("no answer");
  c_pin_low: cover property (@(posedge clock) $fell(errorSignalN));
  c_dtr: cover property (@(posedge clock) config_out.modeCode == 2'h2);
  c_preamble: cover property (@(posedge linkClock) preambleDrive);
endmodule : ofc_config_regs_monitor

// ---- tb/ofc_host_model.sv ----
// host controller model: gated serial clock, one command at a time, dummy phases
// assumes the bench calls one task at a time; the clock stands low when idle
`timescale 1ns/1ps
module ofc_host_model (
  output logic linkClock,
  output logic cmdValid,
  output ofc_pkg::ofc_cmd_type cmdWord,
  output logic dummyActive,
  input wire logic cmdReady,
  input wire logic rspValid
);
  // set before any process runs, so a task started at time zero is not undone
  logic run = 1'b0;
  initial begin
    linkClock = 1'b0;
    cmdValid = 1'b0;
    cmdWord = '0;
    dummyActive = 1'b0;
  end
  always #80 linkClock = run ? ~linkClock : 1'b0;
  // *****************
  // host operations
  // *****************
  task automatic tick(input int n);
    run = 1'b1;
    repeat (n) @(posedge linkClock);
    run = 1'b0;
  endtask : tick
  task automatic xfer(input ofc_pkg::ofc_cmd_type c);
    run = 1'b1;
    @(posedge linkClock);
    cmdValid <= 1'b1;
    cmdWord <= c;
    @(posedge linkClock);
    for (int k = 0; k < 20 && cmdReady !== 1'b1; k++) @(posedge linkClock);
    cmdValid <= 1'b0;
    // released word is scrambled so a stale value cannot pass
    cmdWord <= ofc_pkg::ofc_cmd_type'(~c);
    @(posedge linkClock);
    for (int k = 0; k < 12 && rspValid !== 1'b1; k++) @(posedge linkClock);
    tick(1);
  endtask : xfer
  task automatic dummy(input int n);
    run = 1'b1;
    @(posedge linkClock);
    dummyActive <= 1'b1;
    repeat (n) @(posedge linkClock);
    dummyActive <= 1'b0;
    tick(2);
  endtask : dummy
endmodule : ofc_host_model

// ---- tb/ofc_config_regs_tb.sv ----
// self-checking bench of the flash configuration register bank
// assumes the host model and the checker from the other bench files
`timescale 1ns/1ps
module ofc_config_regs_tb;
  localparam ofc_pkg::ofc_op_type WS = ofc_pkg::OP_WRITE_STATUS;
  localparam ofc_pkg::ofc_op_type RC = ofc_pkg::OP_READ_CONFIG;
  localparam ofc_pkg::ofc_op_type W2 = ofc_pkg::OP_WRITE_CONFIG2;
  localparam ofc_pkg::ofc_op_type R2 = ofc_pkg::OP_READ_CONFIG2;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic eccEvent = 1'b0;
  logic [2:0] eccKind = 3'h0;
  logic linkClock, cmdValid, cmdReady, rspValid, dummyActive, preambleDrive, errorSignalN;
  ofc_pkg::ofc_cmd_type cmdWord;
  ofc_pkg::ofc_cfg_type cfg;
  logic [7:0] rspData, preambleLines, crcChunkBytes, d;
  logic [4:0] dummyCycleCount;
  logic [8:0] expQ[$];
  logic [8:0] e;
  logic [3:0] pIdx = 4'h0;
  logic patSel = 1'b0;
  int nFail = 0, totalChecks = 0, nDrv = 0;
  logic [31:0] adr[6] = '{32'h0, 32'h200, 32'h300, 32'h400, 32'h500, 32'h800};
  logic [7:0] msk[6] = '{8'h03, 8'h03, 8'h07, 8'h03, 8'h71, 8'h00};
  logic [15:0] mw[6] = '{16'h0101, 16'h0201, 16'h0000, 16'h0202, 16'h0302, 16'h0000};

  always #12.5 clock = ~clock;
  ofc_host_model host (.linkClock, .cmdValid, .cmdWord, .dummyActive, .cmdReady, .rspValid);
  ofc_config_regs uut (.clock, .resetn, .linkClock, .cmdValid, .cmdWord, .cmdReady, .rspValid,
    .rspData, .dummyActive, .preambleDrive, .preambleLines, .eccEvent, .eccKind,
    .config_out(cfg), .dummyCycleCount, .crcChunkBytes, .errorSignalN);
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      nFail++;
    end
  endtask : check
  task automatic completeRun();
    if (nFail == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : completeRun
  task automatic wr(input ofc_pkg::ofc_op_type op, input logic [31:0] a, input logic [7:0] v);
    expQ.push_back(9'h000);
    host.xfer(ofc_pkg::ofc_cmd_type'{op, a, v});
  endtask : wr
  task automatic rd(input ofc_pkg::ofc_op_type op, input logic [31:0] a, input logic [7:0] x);
    expQ.push_back({1'b1, x});
    host.xfer(ofc_pkg::ofc_cmd_type'{op, a, ~x});
  endtask : rd
  task automatic ecc(input logic [2:0] k);
    @(posedge clock);
    eccEvent <= 1'b1;
    eccKind <= k;
    @(posedge clock);
    eccEvent <= 1'b0;
    eccKind <= ~k;
    @(posedge clock);
  endtask : ecc
  function automatic logic [7:0] pat(input logic s, input logic [3:0] i);
    logic [15:0] pa, p3;
    logic [7:0] r;
    pa = s ? 16'h5555 : 16'h349a;
    p3 = s ? 16'h5555 : 16'h3514;
    r = {8{pa[4'hf - i]}};
    r[3] = p3[4'hf - i];
    return r;
  endfunction : pat
  // ****************
  // result watcher
  // ****************
  always @(posedge linkClock) begin
    if (rspValid === 1'b1) begin
      e = expQ.pop_front();
      if (e[8]) check(rspData, e[7:0]);
    end
    if (preambleDrive === 1'b1) begin
      check(preambleLines, pat(patSel, pIdx));
      pIdx = pIdx + 4'h1;
      nDrv++;
    end else pIdx = 4'h0;
  end
  initial begin
    #400000;
    nFail++;
    completeRun();
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(53389));
    // one link edge inside reset, else the gated link clock leaves its synchronisers unknown
    fork
      host.tick(1);
      repeat (8) @(posedge clock);
    join
    resetn <= 1'b1;
    host.tick(3);
    check({3'h0, dummyCycleCount}, 8'h14);
    rd(RC, 0, 8'h07);
    foreach (adr[i]) rd(R2, adr[i], 8'h00);
    for (int n = 0; n < 8; n++) begin
      for (int i = 1; i < 5; i++) begin
        d = $urandom;
        if (i == 2) d[2:0] = n[2:0];
        if (i == 4) d[6:5] = n[1:0];
        wr(W2, adr[i], d);
        rd(R2, adr[i], d & msk[i]);
      end
      check({3'h0, dummyCycleCount}, 8'(20 - 2 * n));
      check(crcChunkBytes, 8'h10 << n[1:0]);
    end
    wr(W2, 32'h100, $urandom);
    rd(R2, 32'h100, 8'h00);
    foreach (mw[i]) begin
      wr(W2, 0, mw[i][15:8]);
      rd(R2, 0, mw[i][7:0]);
    end
    d = $urandom;
    d[3] = 1'b1;
    wr(WS, 0, d);
    rd(RC, 0, d & 8'h1f);
    d = $urandom;
    wr(WS, 0, d & 8'hf7);
    rd(RC, 0, (d & 8'h17) | 8'h08);
    for (int s = 0; s < 3; s++) begin
      patSel = s[0];
      wr(W2, 32'h500, {7'h0, s[0]});
      wr(WS, 0, s < 2 ? 8'h17 : 8'h07);
      nDrv = 0;
      host.dummy(20);
      check(nDrv[7:0], s < 2 ? 8'h14 : 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(W2, 32'h400, c[7:0]);
      wr(W2, 32'h800, 8'h00);
      ecc(3'h1);
      check({7'h0, errorSignalN}, {7'h0, ~c[0]});
      ecc(3'h4);
      check({7'h0, errorSignalN}, {7'h0, c == 2});
      rd(R2, 32'h800, 8'hd2);
    end
    @(posedge clock);
    eccEvent <= 1'b1;
    eccKind <= 3'h2;
    repeat (16) @(posedge clock);
    eccEvent <= 1'b0;
    rd(R2, 32'h800, 8'hff);
    wr(W2, 32'h800, 8'h00);
    ecc(3'h0);
    rd(R2, 32'h800, 8'h00);
    check({7'h0, errorSignalN}, 8'h01);
    if (expQ.size() != 0) nFail++;
    completeRun();
  end
endmodule : ofc_config_regs_tb

bind ofc_config_regs ofc_config_regs_monitor mon (.clock, .resetn, .linkClock, .cmdValid,
  .cmdReady, .rspValid, .dummyActive, .preambleDrive, .eccEvent, .eccKind, .config_out,
  .dummyCycleCount, .crcChunkBytes, .errorSignalN);
